//--- rtl/bdc_timer.v
module bdc_timer #(
    parameter W = 16
) (
    // Clock and reset.
    input  wire         i_clk,
    input  wire         i_arst_n,
    // Control.
    input  wire         i_start,
    input  wire         i_tick,
    input  wire [W-1:0] i_len,
    // Status.
    output reg          o_done
);

    reg [W-1:0] remain;

    // A start always reloads, so a new phase never inherits a stale count.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            remain <= {W{1'b0}};
            o_done <= 1'b0;
        end else if (i_start) begin
            remain <= i_len;
            o_done <= (i_len == {W{1'b0}});
        end else if (i_tick && !o_done) begin
            if (remain <= {{(W-1){1'b0}}, 1'b1}) begin
                remain <= {W{1'b0}};
                o_done <= 1'b1;
            end else begin
                remain <= remain - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

//--- rtl/bdc_top.v
//
// Contract
// - Enabling the power stage applies motor current and releases the brake automatically.
// - Operation enabled is permitted only after the full brake release time has elapsed.
// - Brake release and application times come from the motor nameplate timing values.
// - Disabling the power stage applies the holding brake automatically.
// - After the brake is applied, current stays on for the application time, then goes off.
// - Manual brake release is allowed only in operating states 3, 4 and 9.
// - Manual release setting value 0 means automatic handling, 1 requests manual release.
// - Enabling the power stage clears the manual release setting to 0 by itself.
// - A write to the manual release setting acts at once.
// - Inversion setting 1 turns positive targets into negative movement, 0 keeps them.
// - The inversion setting may be changed only while the power stage is disabled.
// - A changed inversion value is applied only after the next power-on.
//
`include "bdc_regs.vh"

module bdc_top #(
    parameter TW      = 16,
    parameter POS_W   = 32,
    parameter TICK_CY = `BDC_CYC_PER_MS
) (
    // Clock and reset.
    input  wire             I_CLK,
    input  wire             I_ARST_N,
    // Power-on event from the drive supervisor.
    input  wire             I_POWER_ON,
    // Drive state machine.
    input  wire             I_STAGE_EN,
    input  wire [3:0]       I_OP_STATE,
    // Motor nameplate timing, in milliseconds.
    input  wire [TW-1:0]    I_NP_RELEASE_MS,
    input  wire [TW-1:0]    I_NP_APPLY_MS,
    // Fieldbus parameter port.
    input  wire             I_PAR_WR,
    input  wire             I_PAR_RD,
    input  wire [15:0]      I_PAR_ADDR,
    input  wire [15:0]      I_PAR_WDATA,
    output reg  [15:0]      O_PAR_RDATA,
    output reg              O_PAR_ACK,
    output reg              O_PAR_ERR,
    // Motion target path.
    input  wire [POS_W-1:0] I_TARGET,
    output reg  [POS_W-1:0] O_TARGET,
    // Power stage, brake and active direction.
    output reg              O_MOTOR_CURRENT,
    output reg              O_BRAKE_RELEASE,
    output reg              O_OP_EN_ALLOWED,
    output reg              O_DIR_ACTIVE
);

    ////////////////////////////////////////////////////////////////////////////
    localparam ST_OFF       = 2'd0;
    localparam ST_RELEASING = 2'd1;
    localparam ST_RUN       = 2'd2;
    localparam ST_APPLYING  = 2'd3;

    localparam [15:0] RST_BRK = `BDC_RST_BRAKE_MANUAL;
    localparam [15:0] RST_DIR = `BDC_RST_DIR_INVERT;

    function manual_state_ok;
        input [3:0] st;
        begin
            manual_state_ok = (st == `BDC_ST_SWITCH_ON_DIS) ||
                              (st == `BDC_ST_READY_SWITCH_ON) ||
                              (st == `BDC_ST_FAULT);
        end
    endfunction

    reg  [1:0]    state;
    reg  [1:0]    next_state;
    reg           stage_q;
    reg           manual_rel;
    reg           dir_stored;
    reg  [31:0]   tick_cnt;
    reg           tick;
    reg           tmr_start;
    reg  [TW-1:0] tmr_len;
    wire          tmr_done;
    wire          stage_rise;
    wire          hit_dir;
    wire          hit_brk;

    assign stage_rise = I_STAGE_EN && !stage_q;
    assign hit_dir    = (I_PAR_ADDR == `BDC_ADDR_DIR_INVERT);
    assign hit_brk    = (I_PAR_ADDR == `BDC_ADDR_BRAKE_MANUAL);

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick for the nameplate times.
    // The divider restarts with every phase: a free-running tick could cut the
    // first millisecond short and open the drive before the brake is fully free.
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            tick_cnt <= 32'h00000000;
            tick     <= 1'b0;
        end else if (tmr_start) begin
            tick_cnt <= 32'h00000000;
            tick     <= 1'b0;
        end else if (tick_cnt >= TICK_CY - 1) begin
            tick_cnt <= 32'h00000000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
            tick     <= 1'b0;
        end
    end

    bdc_timer #(
        .W        (TW)
    ) u_timer (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_start  (tmr_start),
        .i_tick   (tick),
        .i_len    (tmr_len),
        .o_done   (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Brake sequencer.
    always @* begin
        next_state = state;
        tmr_start  = 1'b0;
        tmr_len    = I_NP_RELEASE_MS;
        case (state)
            ST_OFF: begin
                if (I_STAGE_EN) begin
                    next_state = ST_RELEASING;
                    tmr_start  = 1'b1;
                end
            end
            ST_RELEASING: begin
                if (!I_STAGE_EN) begin
                    next_state = ST_APPLYING;
                    tmr_start  = 1'b1;
                    tmr_len    = I_NP_APPLY_MS;
                end else if (tmr_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!I_STAGE_EN) begin
                    next_state = ST_APPLYING;
                    tmr_start  = 1'b1;
                    tmr_len    = I_NP_APPLY_MS;
                end
            end
            default: begin
                // The brake must grip fully before the re-enable can release it again.
                if (tmr_done) begin
                    next_state = ST_OFF;
                end
            end
        endcase
    end

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state   <= ST_OFF;
            stage_q <= 1'b0;
        end else begin
            state   <= next_state;
            stage_q <= I_STAGE_EN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs to the power stage and brake.
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_MOTOR_CURRENT <= 1'b0;
            O_BRAKE_RELEASE <= 1'b0;
            O_OP_EN_ALLOWED <= 1'b0;
        end else begin
            O_MOTOR_CURRENT <= (next_state != ST_OFF);
            O_OP_EN_ALLOWED <= (next_state == ST_RUN);
            // Manual release is gated live by the state, so leaving the permitted
            // states grips the brake without software having to clear the setting.
            O_BRAKE_RELEASE <= (next_state == ST_RELEASING) ||
                               (next_state == ST_RUN) ||
                               ((next_state == ST_OFF) && manual_rel &&
                                manual_state_ok(I_OP_STATE));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parameter registers.
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            manual_rel <= RST_BRK[`BDC_FLD_SETTING_BIT];
            dir_stored <= RST_DIR[`BDC_FLD_SETTING_BIT];
        end else begin
            if (stage_rise) begin
                manual_rel <= 1'b0;
            end else if (I_PAR_WR && hit_brk) begin
                manual_rel <= I_PAR_WDATA[`BDC_FLD_SETTING_BIT];
            end
            if (I_PAR_WR && hit_dir && !I_STAGE_EN && !O_MOTOR_CURRENT) begin
                dir_stored <= I_PAR_WDATA[`BDC_FLD_SETTING_BIT];
            end
        end
    end

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_PAR_ACK   <= 1'b0;
            O_PAR_ERR   <= 1'b0;
            O_PAR_RDATA <= 16'h0000;
        end else begin
            O_PAR_ACK <= I_PAR_WR || I_PAR_RD;
            O_PAR_ERR <= (I_PAR_WR || I_PAR_RD) && !hit_dir && !hit_brk;
            if (I_PAR_WR && hit_dir && (I_STAGE_EN || O_MOTOR_CURRENT)) begin
                O_PAR_ERR <= 1'b1;
            end
            if (I_PAR_RD && hit_dir) begin
                O_PAR_RDATA <= {15'h0000, dir_stored};
            end else if (I_PAR_RD && hit_brk) begin
                O_PAR_RDATA <= {15'h0000, manual_rel};
            end else begin
                O_PAR_RDATA <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Direction inversion; the active copy changes only at power-on.
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_DIR_ACTIVE <= 1'b0;
            O_TARGET     <= {POS_W{1'b0}};
        end else begin
            if (I_POWER_ON) begin
                O_DIR_ACTIVE <= dir_stored;
            end
            O_TARGET <= O_DIR_ACTIVE ? (~I_TARGET + {{(POS_W-1){1'b0}}, 1'b1})
                                     : I_TARGET;
        end
    end

endmodule

//--- shared/bdc_regs.vh
`ifndef BDC_REGS_VH
`define BDC_REGS_VH

// Parameter addresses on the fieldbus parameter port.
`define BDC_ADDR_DIR_INVERT     16'h0618
`define BDC_ADDR_BRAKE_MANUAL   16'h0814

// Field positions and reset values.
`define BDC_FLD_SETTING_BIT     0
`define BDC_RST_DIR_INVERT      16'h0000
`define BDC_RST_BRAKE_MANUAL    16'h0000

// Operating states in which the brake may be released by hand.
`define BDC_ST_SWITCH_ON_DIS    4'h3
`define BDC_ST_READY_SWITCH_ON  4'h4
`define BDC_ST_FAULT            4'h9

// Timing: nameplate times are given in milliseconds.
`define BDC_CLK_HZ              125000000
`define BDC_TICK_MS             1
`define BDC_CYC_PER_MS          ((`BDC_CLK_HZ / 1000) * `BDC_TICK_MS)

`endif

//--- test/bdc_motor_model.sv
// Motor side: the nameplate record that the drive reads for its brake timing.
module bdc_motor #(
    parameter int REL_MS = 2,
    parameter int APP_MS = 2
) (
    output logic [15:0] o_np_release_ms,
    output logic [15:0] o_np_apply_ms
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_np_release_ms = REL_MS[15:0];
    assign o_np_apply_ms   = APP_MS[15:0];
endmodule

//--- test/bdc_top_properties.sv
`include "bdc_regs.vh"
module bdc_chk #(
    parameter POS_W = 32
) (
    input wire             I_CLK, I_ARST_N, I_POWER_ON, I_STAGE_EN, I_PAR_WR, I_PAR_RD,
    input wire [3:0]       I_OP_STATE,
    input wire [15:0]      I_NP_RELEASE_MS, I_NP_APPLY_MS, I_PAR_ADDR, I_PAR_WDATA,
    input wire [15:0]      O_PAR_RDATA,
    input wire             O_PAR_ACK, O_PAR_ERR, O_MOTOR_CURRENT, O_BRAKE_RELEASE,
    input wire             O_OP_EN_ALLOWED, O_DIR_ACTIVE,
    input wire [POS_W-1:0] I_TARGET, O_TARGET
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    // Depths below assume nameplate times of at least 2 ms, 8 cycles at the bench tick rate.
    property p_rel; $rose(I_STAGE_EN) && !O_MOTOR_CURRENT |=> O_MOTOR_CURRENT && O_BRAKE_RELEASE; endproperty
    a_rel: assert property (p_rel) else $error("brake not released on enable");
    property p_opw; $rose(O_OP_EN_ALLOWED) |-> $past(O_BRAKE_RELEASE, 8) && O_MOTOR_CURRENT; endproperty
    a_opw: assert property (p_opw) else $error("operation allowed too early");
    property p_app; $fell(I_STAGE_EN) |=> !O_BRAKE_RELEASE && !O_OP_EN_ALLOWED; endproperty
    a_app: assert property (p_app) else $error("brake not applied on disable");
    property p_hold; $fell(O_BRAKE_RELEASE) && O_MOTOR_CURRENT |-> O_MOTOR_CURRENT[*8]; endproperty
    a_hold: assert property (p_hold) else $error("current dropped during apply");
    property p_man; O_BRAKE_RELEASE && !O_MOTOR_CURRENT |-> $past(I_OP_STATE) inside {4'h3, 4'h4, 4'h9}; endproperty
    a_man: assert property (p_man) else $error("manual release in wrong state");
    property p_tgt; !I_POWER_ON && !$past(I_POWER_ON) |=> O_TARGET == (O_DIR_ACTIVE ? -$past(I_TARGET) : $past(I_TARGET)); endproperty
    a_tgt: assert property (p_tgt) else $error("target direction wrong");
    property p_dir; !I_POWER_ON |=> $stable(O_DIR_ACTIVE); endproperty
    a_dir: assert property (p_dir) else $error("direction changed without power-on");
    property p_inv; I_PAR_WR && I_PAR_ADDR == `BDC_ADDR_DIR_INVERT && I_STAGE_EN |=> O_PAR_ACK && O_PAR_ERR; endproperty
    a_inv: assert property (p_inv) else $error("inversion write not refused");
    c_run: cover property (O_OP_EN_ALLOWED);
    c_man: cover property (O_BRAKE_RELEASE && !O_MOTOR_CURRENT);
    c_dir: cover property (O_DIR_ACTIVE);
endmodule
bind bdc_top bdc_chk #(.POS_W(POS_W)) chk_u (.*);

//--- test/brake_and_direction_control_tb_top.sv
`include "bdc_regs.vh"
module brake_and_direction_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, pon = 0, en = 0, wr = 0, rd = 0;
    logic [3:0]  st = 4'h3;
    logic [15:0] addr = 16'h0000, wd = 16'h0000, rel_ms, app_ms, rdata;
    logic [31:0] tgt = 32'h0000_0005, otgt;
    logic        ack, err, cur, brk, opok, dir;
    int          n_errors = 0, num_checks = 0, cyc = 0, n;
    bdc_top #(.TICK_CY(4)) dut_u (.I_CLK(clk), .I_ARST_N(rst_n), .I_POWER_ON(pon),
        .I_STAGE_EN(en), .I_OP_STATE(st), .I_NP_RELEASE_MS(rel_ms), .I_NP_APPLY_MS(app_ms),
        .I_PAR_WR(wr), .I_PAR_RD(rd), .I_PAR_ADDR(addr), .I_PAR_WDATA(wd), .O_PAR_RDATA(rdata),
        .O_PAR_ACK(ack), .O_PAR_ERR(err), .I_TARGET(tgt), .O_TARGET(otgt),
        .O_MOTOR_CURRENT(cur), .O_BRAKE_RELEASE(brk), .O_OP_EN_ALLOWED(opok), .O_DIR_ACTIVE(dir));
    bdc_motor motor_u (.o_np_release_ms(rel_ms), .o_np_apply_ms(app_ms));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One parameter access; returns in the cycle where the answer stands.
    // An edge passes first, so a strobe never rises in the step that lowered it.
    task automatic par(input logic w, input logic [15:0] a, input logic [15:0] d);
        tick(1);
        wr = w;
        rd = !w;
        addr = a;
        wd = d;
        tick(1);
        wr = 0;
        rd = 0;
        check(ack, 1);
    endtask
    task automatic wait_off;
        for (n = 0; n < 40 && cur !== 1'b0; n++) tick(1);
    endtask
    task automatic t_manual;
        par(0, `BDC_ADDR_BRAKE_MANUAL, 0);
        check(rdata, `BDC_RST_BRAKE_MANUAL);
        par(0, `BDC_ADDR_DIR_INVERT, 0);
        check(rdata, `BDC_RST_DIR_INVERT);
        par(1, 16'h0700, 1);
        check(err, 1);
        for (int s = 0; s < 10; s++) begin
            st = s[3:0];
            par(1, `BDC_ADDR_BRAKE_MANUAL, 1);
            tick(1);
            check(brk, s == 3 || s == 4 || s == 9);
        end
        par(1, `BDC_ADDR_BRAKE_MANUAL, 0);
        tick(1);
        check(brk, 0);
    endtask
    task automatic t_seq;
        st = 4'h4;
        par(1, `BDC_ADDR_BRAKE_MANUAL, 1);
        en = 1;
        tick(2);
        check({cur, brk, opok}, 3'b110);
        for (n = 0; n < 40 && opok !== 1'b1; n++) tick(1);
        check(n >= 7 && opok === 1'b1, 1);
        par(0, `BDC_ADDR_BRAKE_MANUAL, 0);
        check(rdata, 0);
        en = 0;
        tick(2);
        check({cur, brk, opok}, 3'b100);
        wait_off();
        check(n >= 7 && cur === 1'b0, 1);
    endtask
    task automatic t_dir;
        en = 1;
        tick(2);
        par(1, `BDC_ADDR_DIR_INVERT, 1);
        check(err, 1);
        par(0, `BDC_ADDR_DIR_INVERT, 0);
        check(rdata, 0);
        en = 0;
        tick(2);
        wait_off();
        par(1, `BDC_ADDR_DIR_INVERT, 1);
        check(err, 0);
        tgt = 32'h0000_0123;
        tick(2);
        check({dir, otgt}, {1'b0, tgt});
        pon = 1;
        tick(1);
        pon = 0;
        tick(2);
        check({dir, otgt}, {1'b1, 32'h0 - tgt});
    endtask
    initial begin
        tick(10);
        rst_n = 1;
        t_manual();
        t_seq();
        t_dir();
        report_and_stop();
    end
endmodule
